// ### bench/pcl_monitor.sv
// concurrent checks on the loop control ports
`timescale 1ns/100ps
`default_nettype none
module pcl_monitor
  import pcl_pkg::*;
(
  input wire logic        clk_sys, arst_n, ref_clock_in, source_select, low_power_hold,
  input wire logic        hold_enable_a, hold_enable_b, loop_reset_n,
  input wire pcl_fb_type  fb_path,
  input wire pcl_dly_type delay_mode,
  input wire logic        global_clock_out, fabric_clock_out, lock
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [4:0] idle;
  logic       ref_q;
  wire        hold_on = low_power_hold && hold_enable_a && hold_enable_b;
  // cycles since the reference last moved, saturating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle  <= 5'h00;
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_clock_in;
      idle  <= (ref_q != ref_clock_in) ? 5'h00 : idle + 5'(idle != 5'h1F);
    end
  end
  a_fabric_same: assert property (fabric_clock_out == global_clock_out)
    else $error("fabric output differs from global output");
  a_lock_reset: assert property (!loop_reset_n [*4] |-> !lock)
    else $error("lock high under loop reset");
  a_release_quiet: assert property ($rose(arst_n) |-> !lock && !global_clock_out)
    else $error("outputs not low after reset release");
  a_lock_idle: assert property (idle > 5'd24 |-> !lock)
    else $error("lock held without reference edges");
  a_hold_lock: assert property (hold_on [*6] |-> !lock)
    else $error("lock high during hold");
  a_hold_freeze: assert property (hold_on [*8] |-> $stable(global_clock_out))
    else $error("output moved during hold");
  a_loop_idle: assert property ((!lock && !source_select && !low_power_hold
    && fb_path == PCL_FB_SIMPLE) [*8] |-> !global_clock_out)
    else $error("loop clock present while unlocked");
  a_bypass_ref: assert property ($rose(global_clock_out) && source_select && $past(source_select, 8)
    && fb_path == PCL_FB_SIMPLE && delay_mode == PCL_DLY_FIXED |-> $past(ref_clock_in, 5))
    else $error("bypass output rose without reference");
  c_lock: cover property ($rose(lock));
  c_bypass: cover property ($rose(global_clock_out) && source_select);
  c_hold: cover property (hold_on && !lock);
endmodule // pcl_monitor
bind pcl_control pcl_monitor u_mon (.*);
`default_nettype wire

// ### bench/pcl_ref_source.sv
// reference and feedback clock source facing the loop inputs
`timescale 1ns/100ps
`default_nettype none
module pcl_ref_source (
  input  wire logic run,
  input  wire logic fb_good,
  output var  logic ref_clock_in,
  output var  logic ext_fb_clock_in
);
  // 48 ns period, parked low between bursts, inside the allowed range
  initial ref_clock_in = 1'b0;
  always #24 ref_clock_in = run ? !ref_clock_in : 1'b0;
  // feedback mirrors the reference unless told to break pairing
  assign ext_fb_clock_in = fb_good ? ref_clock_in : 1'b0;
endmodule // pcl_ref_source
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the loop control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pcl_pkg::*;
  logic        clk_sys = 1'b0, arst_n = 1'b0, run = 1'b0, fb_good = 1'b1, source_select = 1'b0;
  logic        low_power_hold = 1'b0, hold_enable_a = 1'b0, hold_enable_b = 1'b0;
  logic        loop_reset_n = 1'b0;
  logic [3:0]  fine_delay_ctrl = 4'h0;
  pcl_fb_type  fb_path = PCL_FB_SIMPLE;
  pcl_dly_type delay_mode = PCL_DLY_FIXED;
  wire logic   ref_clock_in, ext_fb_clock_in, global_clock_out, fabric_clock_out, lock;
  int          fails = 0, comparisons = 0, seed = 32'hce1d, rises = 0, i, k;
  logic        lock_q[$];
  int          rise_q[$];
  event        look_lock, look_rise, look_delay;
  int          lat_q[$];
  int          lat = 0;
  localparam int BASE_LAT = 5;
  always #2 clk_sys = !clk_sys;
  always @(posedge global_clock_out) rises++;
  pcl_ref_source u_src (.*);
  pcl_control dut (.*);
  task automatic complete_run;
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_lock(logic e);
    comparisons++;
    if (lock !== e) begin fails++; $display("FAIL lock exp %b seen %b", e, lock); end
  endtask
  task automatic check_rises(int e);
    comparisons++;
    if (rises != e) begin fails++; $display("FAIL rises exp %0d seen %0d", e, rises); end
  endtask
  task automatic check_delay(int e);
    comparisons++;
    if (lat != e) begin fails++; $display("FAIL delay exp %0d seen %0d", e, lat); end
  endtask
  // watcher side pops the oldest note whenever a result is due
  always @(look_delay) check_delay(lat_q.pop_front());
  always @(look_lock) check_lock(lock_q.pop_front());
  always @(look_rise) check_rises(rise_q.pop_front());
  task automatic note_lock(logic e); lock_q.push_back(e); ->look_lock; endtask
  // 120 cycles hold exactly ten 12-cycle reference periods
  task automatic note_rises(int e);
    repeat (16) @(negedge clk_sys);
    rises = 0;
    repeat (120) @(negedge clk_sys);
    rise_q.push_back(e);
    ->look_rise;
  endtask
  // cycles from a fresh reference edge to the first bypass output edge
  task automatic note_delay(logic [3:0] t);
    lat_q.push_back(BASE_LAT + int'(t));
    run = 1'b0;
    repeat (40) @(negedge clk_sys);
    run = 1'b1;
    for (lat = 0; lat < 40 && ref_clock_in !== 1'b1; lat++) @(posedge clk_sys);
    if (lat == 40) fails++;
    for (lat = 0; lat < 40 && global_clock_out !== 1'b1; lat++) @(negedge clk_sys);
    ->look_delay;
  endtask
  task automatic wait_lock;
    for (i = 0; i < 400 && lock !== 1'b1; i++) @(negedge clk_sys);
    if (i == 400) begin fails++; complete_run; end
  endtask
  // configuration changes only under loop reset, random tap
  task automatic cfg(pcl_fb_type p, logic g);
    loop_reset_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    fb_path = p;
    fb_good = g;
    fine_delay_ctrl = 4'($random(seed));
    loop_reset_n = 1'b1;
    repeat (100) @(negedge clk_sys);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    run = 1'b1;
    note_lock(1'b0);
    source_select = 1'b1;
    note_rises(10);
    source_select = 1'b0;
    note_rises(0);
    note_lock(1'b0);
    loop_reset_n = 1'b1;
    wait_lock;
    note_lock(1'b1);
    note_rises(10);
    cfg(PCL_FB_SIMPLE, 1'b0); note_lock(1'b1);
    cfg(PCL_FB_EXTERNAL, 1'b0); note_lock(1'b0);
    cfg(PCL_FB_EXTERNAL, 1'b1); note_lock(1'b1);
    cfg(PCL_FB_INTERNAL, 1'b0); note_lock(1'b1);
    for (k = 1; k < 4; k++) begin
      hold_enable_a = k[0];
      hold_enable_b = k[1];
      low_power_hold = 1'b1;
      note_rises(k == 3 ? 0 : 10);
      note_lock(k != 3);
      low_power_hold = 1'b0;
      wait_lock;
    end
    delay_mode = PCL_DLY_DYNAMIC;
    note_rises(10);
    fb_path = PCL_FB_SIMPLE;
    source_select = 1'b1;
    fine_delay_ctrl = 4'($random(seed));
    note_delay(fine_delay_ctrl);
    run = 1'b0;
    repeat (40) @(negedge clk_sys);
    note_lock(1'b0);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire

// ### core/pcl_control.sv
// digital control and status around the phase-locked loop
//
// Functional notes
// - with the simple feedback path, source select 0 passes the loop clock and 1 the reference.
// - the external feedback input counts only when the feedback path is external.
// - fine delay steers the output only in dynamic delay mode.
// - hold request with the feature enabled freezes the output at its last level.
// - the global output feeds the global network, ideally buffers four and five.
// - the fabric output carries the same clock as the global output.
// - lock is high only while the output is aligned to the reference.
// - reset is active low; high means run.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_regs.svh"
module pcl_control
  import pcl_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  input  wire logic                    ref_clock_in,
  input  wire logic                    ext_fb_clock_in,
  input  wire logic                    source_select,
  input  wire pcl_fb_type              fb_path,
  input  wire pcl_dly_type             delay_mode,
  input  wire logic [`PCL_DELAY_W-1:0] fine_delay_ctrl,
  input  wire logic                    low_power_hold,
  input  wire logic                    hold_enable_a,
  input  wire logic                    hold_enable_b,
  input  wire logic                    loop_reset_n,
  output var  logic                    global_clock_out,
  output var  logic                    fabric_clock_out,
  output var  logic                    lock
);
  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------
  // rising edge of a synchronised level against its delayed copy
  function automatic logic pcl_rise(input logic now_lvl, input logic old_lvl);
    return now_lvl & ~old_lvl;
  endfunction
  // feedback path decode, shared by the source pick and the edge pick
  function automatic logic pcl_is_path(input pcl_fb_type path, input pcl_fb_type want);
    return (path == want);
  endfunction
  // --------------------------------------------------------------
  // input synchronisers, two stages each
  // --------------------------------------------------------------
  // pins arrive from outside clk_sys; only the second stage is read
  logic [1:0]             ref_s;          // reference clock pin
  logic [1:0]             fb_s;           // external feedback pin
  logic [1:0]             hold_s;         // hold request pin
  logic [1:0]             rst_s;          // loop reset pin, active low
  logic                   ref_d;          // reference, one cycle later
  logic                   fb_d;           // feedback, one cycle later
  // tracker state, declared early because the clock pick reads it
  pcl_state_type          state;
  pcl_state_type          next_state;
  logic [`PCL_LOCK_W-1:0] lock_cnt;
  logic [`PCL_LOCK_W-1:0] next_lock_cnt;
  logic [`PCL_LOCK_W-1:0] gap_cnt;
  logic [`PCL_LOCK_W-1:0] next_gap_cnt;
  // synchroniser flops; reset to the idle low level of the pins
  // so that no false rising edge follows reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_s  <= '0;
      fb_s   <= '0;
      hold_s <= '0;
      rst_s  <= '0;
      ref_d  <= 1'b0;
      fb_d   <= 1'b0;
    end else begin
      ref_s  <= {ref_s[0], ref_clock_in};
      fb_s   <= {fb_s[0], ext_fb_clock_in};
      hold_s <= {hold_s[0], low_power_hold};
      rst_s  <= {rst_s[0], loop_reset_n};
      ref_d  <= ref_s[1];
      fb_d   <= fb_s[1];
    end
  end
  // --------------------------------------------------------------
  // edge detection and selection
  // --------------------------------------------------------------
  // edges are found in the same cycle the second stage takes the new level
  wire ref_rise   = pcl_rise(ref_s[1], ref_d);
  wire fb_rise    = pcl_rise(fb_s[1], fb_d);
  wire loop_run   = rst_s[1];
  // configuration decode; these inputs are meant to stay static
  wire use_ext    = pcl_is_path(fb_path, PCL_FB_EXTERNAL);
  wire use_simple = pcl_is_path(fb_path, PCL_FB_SIMPLE);
  // feedback edge: external input, else the reference edge itself
  wire fb_edge    = use_ext ? fb_rise : ref_rise;
  // hold acts only with both enables set; a lone enable is ignored
  wire hold_on    = hold_s[1] & hold_enable_a & hold_enable_b;
  // bypass exists only on the simple path; other paths always
  // present the loop clock whatever source select says
  wire bypass     = use_simple && (source_select == `PCL_SRC_REF);
  // fixed mode forces tap zero so a stale fine delay does nothing
  wire [`PCL_DELAY_W-1:0] tap_sel =
    (delay_mode == PCL_DLY_DYNAMIC) ? fine_delay_ctrl : `PCL_DELAY_ZERO;
  // loop clock is modelled as the reference regenerated while locked;
  // limitation: no multiply or divide, the output runs at the
  // reference rate sampled on clk_sys
  wire loop_clk   = (state == PCL_ST_LOCKED) ? ref_s[1] : 1'b0;
  wire pick_clk   = bypass ? ref_s[1] : loop_clk;
  // --------------------------------------------------------------
  // lock tracker: counts aligned clk_sys cycles while acquiring
  // --------------------------------------------------------------
  // a cycle is aligned unless a reference edge arrives without feedback
  wire aligned    = ~ref_rise | fb_edge;
  wire gap_full   = (gap_cnt == `PCL_LOCK_W'(`PCL_EDGE_TIMEOUT));
  wire lock_done  = (lock_cnt == `PCL_LOCK_W'(`PCL_LOCK_CYCLES));
  wire in_acq     = (state == PCL_ST_ACQ);
  // lock count restarts on any misalignment or missing reference
  assign next_lock_cnt = (!in_acq || !aligned || gap_full) ? '0 :
                         (lock_done ? lock_cnt : lock_cnt + `PCL_LOCK_W'(1));
  // gap count measures time since the last reference edge; a parked
  // reference drops lock instead of leaving a stale lock standing
  assign next_gap_cnt  = (ref_rise || gap_full) ? '0 : gap_cnt + `PCL_LOCK_W'(1);
  // next state; loop reset always wins over every other request
  always_comb begin
    next_state = state;
    case (state)
      PCL_ST_RESET: begin
        if (loop_run) next_state = PCL_ST_ACQ;
      end
      PCL_ST_ACQ: begin
        if (!loop_run) next_state = PCL_ST_RESET;
        else if (hold_on) next_state = PCL_ST_HOLD;
        else if (lock_done) next_state = PCL_ST_LOCKED;
      end
      PCL_ST_LOCKED: begin
        if (!loop_run) next_state = PCL_ST_RESET;
        else if (hold_on) next_state = PCL_ST_HOLD;
        else if (!aligned || gap_full) next_state = PCL_ST_ACQ;
      end
      PCL_ST_HOLD: begin
        // leaving hold always reacquires; the loop lost track meanwhile
        if (!loop_run) next_state = PCL_ST_RESET;
        else if (!hold_on) next_state = PCL_ST_ACQ;
      end
      default: begin
        next_state = PCL_ST_RESET;
      end
    endcase
  end
  // state and counters
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= PCL_ST_RESET;
      lock_cnt <= '0;
      gap_cnt  <= '0;
    end else begin
      state    <= next_state;
      lock_cnt <= next_lock_cnt;
      gap_cnt  <= next_gap_cnt;
    end
  end
  // --------------------------------------------------------------
  // delay line and output stage
  // --------------------------------------------------------------
  // the delay line runs on clk_sys, so one tap is one system cycle;
  // finer steps would need a faster clock than this block has
  pcl_tap_if tap ();
  assign tap.clk_in = pick_clk;
  assign tap.sel    = tap_sel;
  pcl_delay_line u_line (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tap     (tap.line)
  );
  // lock follows the next state so it drops together with the state
  wire next_lock  = (next_state == PCL_ST_LOCKED) && loop_run;
  // hold keeps the last level in any state: the flops stop loading
  wire out_load   = ~hold_on;
  // both clock outputs share one source so they can never drift apart
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      global_clock_out <= 1'b0;
      fabric_clock_out <= 1'b0;
    end else if (out_load) begin
      global_clock_out <= tap.clk_out;
      fabric_clock_out <= tap.clk_out;
    end
  end
  // lock flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock <= 1'b0;
    end else begin
      lock <= next_lock;
    end
  end
endmodule // pcl_control
`default_nettype wire

// ### core/pcl_delay_line.sv
// sixteen-tap shift delay line for the selected clock level
`timescale 1ns/100ps
`default_nettype none
`include "pcl_regs.svh"
module pcl_delay_line (
  input  wire logic   clk_sys,
  input  wire logic   arst_n,
  pcl_tap_if.line     tap
);
  logic [`PCL_TAPS-1:0] taps;
  // --------------------------------------------------------------
  // shift chain with registered tap pick
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      taps        <= '0;
      tap.clk_out <= 1'b0;
    end else begin
      taps        <= {taps[`PCL_TAPS-2:0], tap.clk_in};
      tap.clk_out <= taps[tap.sel];
    end
  end
endmodule // pcl_delay_line
`default_nettype wire

// ### core/pcl_pkg.sv
// types for the loop control interface
package pcl_pkg;
  typedef enum logic [1:0] {
    PCL_FB_SIMPLE   = 2'h0,
    PCL_FB_EXTERNAL = 2'h1,
    PCL_FB_INTERNAL = 2'h2
  } pcl_fb_type;
  typedef enum logic [0:0] {
    PCL_DLY_FIXED   = 1'h0,
    PCL_DLY_DYNAMIC = 1'h1
  } pcl_dly_type;
  typedef enum logic [3:0] {
    PCL_ST_RESET  = 4'h1,
    PCL_ST_ACQ    = 4'h2,
    PCL_ST_LOCKED = 4'h4,
    PCL_ST_HOLD   = 4'h8
  } pcl_state_type;
endpackage

// ### core/pcl_regs.svh
// timing and field constants for the loop control interface
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH
`define PCL_SRC_LOOP        1'h0
`define PCL_SRC_REF         1'h1
`define PCL_LOCK_TIME_NS    200
`define PCL_CLK_PERIOD_NS   4
`define PCL_LOCK_CYCLES     ((`PCL_LOCK_TIME_NS + `PCL_CLK_PERIOD_NS - 1) / `PCL_CLK_PERIOD_NS)
`define PCL_LOCK_W          8
`define PCL_EDGE_TIMEOUT    16
`define PCL_DELAY_W         4
`define PCL_DELAY_ZERO      4'h0
`define PCL_TAPS            16
`endif

// ### core/pcl_tap_if.sv
// bundle between the top and the delay line
`timescale 1ns/100ps
`default_nettype none
`include "pcl_regs.svh"
interface pcl_tap_if;
  logic                    clk_in;
  logic [`PCL_DELAY_W-1:0] sel;
  logic                    clk_out;
  modport top  (output clk_in, output sel, input clk_out);
  modport line (input clk_in, input sel, output clk_out);
endinterface
`default_nettype wire
